// >>> verilog/cts_pkg.sv
// constants and carriers shared by the channel transfer sequencer
package cts_pkg;

    // register byte offsets within one channel's half of the map
    localparam logic [7:0] CTS_OFS_PTR_HI = 8'h4c; // address bits 19..16
    localparam logic [7:0] CTS_OFS_PTR_MD = 8'h4a; // address bits 15..8
    localparam logic [7:0] CTS_OFS_PTR_LO = 8'h4e; // address bits 7..0
    localparam logic [7:0] CTS_OFS_CNT_HI = 8'h50; // count bits 15..8
    localparam logic [7:0] CTS_OFS_CNT_LO = 8'h52; // count bits 7..0
    localparam logic [7:0] CTS_OFS_GO = 8'h54;
    localparam logic [7:0] CTS_OFS_HALT = 8'h56;
    localparam logic [7:0] CTS_OFS_CAPT = 8'h58;

    // byte field positions inside the pointer and counter
    localparam int CTS_HI_LSB = 16;
    localparam int CTS_MD_LSB = 8;
    localparam int CTS_HI_W = 4;

    // reset values
    localparam logic [7:0] CTS_RD_ZERO = 8'h00;

    // command synchronisation: clocks from write to state advance
    localparam int CTS_SYNC_CLKS = 10;
    localparam int CTS_SYNC_W = 4;

    // processor register access, one cycle per strobe
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cts_bus_s;

    // channel status seen by the rest of the device
    typedef struct packed {
        logic busy;
        logic very_busy;
        logic cmd_reject;
        logic sync_busy;
    } cts_stat_s;

    // synchronised command pulses
    typedef struct packed {
        logic go;
        logic halt;
        logic capt;
    } cts_cmd_s;

endpackage : cts_pkg

// >>> verilog/cts_cmd_sync.sv
// ten-clock synchroniser for start, stop and capture commands
`timescale 1ns/1ps
module cts_cmd_sync
    import cts_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // raw command writes, one-cycle pulses
    input wire cts_pkg::cts_cmd_s cmd_in,
    // delayed command pulses and busy level
    output cts_pkg::cts_cmd_s cmd_out,
    output logic sync_busy
);
    import cts_pkg::*;

    logic [CTS_SYNC_W-1:0] cnt_ff;
    logic [CTS_SYNC_W-1:0] nxt_cnt;
    cts_cmd_s held_ff;
    cts_cmd_s nxt_held;
    cts_cmd_s out_ff;
    cts_cmd_s nxt_out;

    localparam logic [CTS_SYNC_W-1:0] LAST = CTS_SYNC_W'(CTS_SYNC_CLKS - 1);
    localparam logic [CTS_SYNC_W-1:0] ONE = CTS_SYNC_W'(1);

    // a command is held while its count runs; writes meanwhile are dropped,
    // since firmware keeps off channel registers for that window
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_held = held_ff;
        nxt_out = '0;
        if (cnt_ff == '0)
        begin
            if (cmd_in != '0)
            begin
                nxt_cnt = ONE;
                nxt_held = cmd_in;
            end
        end
        else if (cnt_ff == LAST)
        begin
            nxt_out = held_ff; // fires so the state moves at clock ten
            nxt_cnt = '0;
            nxt_held = '0;
        end
        else
        begin
            nxt_cnt = cnt_ff + ONE;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt_ff <= '0;
            held_ff <= '0;
            out_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            held_ff <= nxt_held;
            out_ff <= nxt_out;
        end
    end

    assign cmd_out = out_ff;
    assign sync_busy = (cnt_ff != '0);

endmodule : cts_cmd_sync

// >>> verilog/cts_channel.sv
// per-channel transfer sequencer: pointer, byte counter, start/stop fsm
`timescale 1ns/1ps
module cts_channel
    import cts_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // processor register access
    input wire cts_pkg::cts_bus_s bus,
    output logic [7:0] rd_data,
    // data path events
    input wire logic byte_done,
    input wire logic byte_is_redund,
    input wire logic xfer_err,
    input wire logic err_uncleared,
    // channel control bits
    input wire logic ecc_idle_en,
    input wire logic slave_mode,
    // channel state
    output cts_pkg::cts_stat_s stat,
    output logic xfer_active,
    output logic pio_enable,
    output logic [ADDR_W-1:0] buf_addr,
    output logic [CNT_W-1:0] bytes_left
);
    import cts_pkg::*;

    // the byte lanes below assume the documented widths
    if (ADDR_W != CTS_HI_LSB + CTS_HI_W || CNT_W != 2 * CTS_MD_LSB)
    begin : g_width_check
        $error("cts_channel: widths do not match the byte lanes");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BUSY,
        ST_VBUSY,
        ST_VBUSY_REJ,
        ST_REJECT
    } cts_state_e;

    // register decode ignores bit 0 and the channel select bit 7
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[6:1] == ofs[6:1]);
    endfunction : hit

    cts_state_e state_ff;
    cts_state_e nxt_state;
    logic [ADDR_W-1:0] addr_pipe_ff;
    logic [ADDR_W-1:0] nxt_addr_pipe;
    logic [ADDR_W-1:0] addr_cnt_ff;
    logic [ADDR_W-1:0] nxt_addr_cnt;
    logic [ADDR_W-1:0] addr_capt_ff;
    logic [ADDR_W-1:0] nxt_addr_capt;
    logic [CNT_W-1:0] cnt_pipe_ff;
    logic [CNT_W-1:0] nxt_cnt_pipe;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] cnt_capt_ff;
    logic [CNT_W-1:0] nxt_cnt_capt;
    logic load_pend_ff;
    logic nxt_load_pend;
    logic reject_ff;
    logic nxt_reject;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    cts_cmd_s cmd_raw;
    cts_cmd_s cmd;
    logic sync_busy;
    logic active;
    logic done;
    logic count_byte;

    // raw command strobes, delayed by the synchroniser
    assign cmd_raw.go = bus.wr && hit(bus.addr, CTS_OFS_GO);
    assign cmd_raw.halt = bus.wr && hit(bus.addr, CTS_OFS_HALT);
    assign cmd_raw.capt = bus.wr && hit(bus.addr, CTS_OFS_CAPT);

    cts_cmd_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .cmd_in(cmd_raw),
        .cmd_out(cmd),
        .sync_busy(sync_busy)
    );

    // transfer progress; redundancy bytes are skipped under idle enable
    // so the count spans only the data between redundancy fields
    assign active = (state_ff == ST_BUSY) || (state_ff == ST_VBUSY)
        || (state_ff == ST_VBUSY_REJ);
    assign count_byte = active && byte_done && (cnt_ff != '0)
        && !(ecc_idle_en && byte_is_redund);
    assign done = active && (cnt_ff == '0);

    // counters, pipelines, latches and the command state machine
    always_comb
    begin
        nxt_state = state_ff;
        nxt_addr_pipe = addr_pipe_ff;
        nxt_addr_cnt = addr_cnt_ff;
        nxt_addr_capt = addr_capt_ff;
        nxt_cnt_pipe = cnt_pipe_ff;
        nxt_cnt = cnt_ff;
        nxt_cnt_capt = cnt_capt_ff;
        nxt_load_pend = load_pend_ff;
        nxt_reject = reject_ff;

        // running counters advance once per byte
        if (count_byte)
        begin
            nxt_addr_cnt = addr_cnt_ff + ADDR_W'(1);
            nxt_cnt = cnt_ff - CNT_W'(1);
        end

        if (cmd.halt)
        begin
            nxt_state = ST_IDLE;
            nxt_reject = 1'b0;
        end
        else if (active && xfer_err)
        begin
            nxt_addr_capt = addr_cnt_ff;
            nxt_cnt_capt = cnt_ff;
            nxt_state = ST_IDLE;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (cmd.go && err_uncleared)
                    begin
                        nxt_state = ST_REJECT;
                        nxt_reject = 1'b1;
                    end
                    else if (cmd.go)
                    begin
                        nxt_state = ST_BUSY;
                        nxt_cnt = cnt_pipe_ff;
                        if (load_pend_ff)
                        begin
                            nxt_addr_cnt = addr_pipe_ff;
                        end
                        nxt_load_pend = 1'b0;
                    end
                end
                ST_BUSY:
                begin
                    if (done)
                    begin
                        nxt_state = ST_IDLE;
                        nxt_addr_capt = addr_cnt_ff;
                        nxt_cnt_capt = cnt_ff;
                    end
                    if (cmd.go)
                    begin
                        nxt_state = ST_VBUSY;
                    end
                end
                ST_VBUSY:
                begin
                    if (cmd.go)
                    begin
                        nxt_reject = 1'b1;
                        nxt_state = done ? ST_REJECT : ST_VBUSY_REJ;
                    end
                    else if (done)
                    begin
                        nxt_state = ST_BUSY;
                        nxt_cnt = cnt_pipe_ff;
                        if (load_pend_ff)
                        begin
                            nxt_addr_cnt = addr_pipe_ff;
                        end
                        nxt_load_pend = 1'b0;
                    end
                end
                ST_VBUSY_REJ:
                begin
                    // queued values are taken as corrupted and not loaded here; they stay queued for the next start from idle
                    if (done)
                    begin
                        nxt_state = ST_REJECT;
                    end
                end
                ST_REJECT:
                begin
                    nxt_state = ST_REJECT;
                end
            endcase
        end

        // a capture write wins over the automatic captures above
        if (cmd.capt)
        begin
            nxt_addr_capt = addr_cnt_ff;
            nxt_cnt_capt = cnt_ff;
        end

        // pipeline writes are accepted in any state, busy included;
        // a write in the clearing cycle leaves the flag set
        if (bus.wr && hit(bus.addr, CTS_OFS_PTR_HI))
        begin
            nxt_addr_pipe[ADDR_W-1:CTS_HI_LSB] = bus.wdata[CTS_HI_W-1:0];
            nxt_load_pend = 1'b1;
        end
        if (bus.wr && hit(bus.addr, CTS_OFS_PTR_MD))
        begin
            nxt_addr_pipe[CTS_HI_LSB-1:CTS_MD_LSB] = bus.wdata;
            nxt_load_pend = 1'b1;
        end
        if (bus.wr && hit(bus.addr, CTS_OFS_PTR_LO))
        begin
            nxt_addr_pipe[CTS_MD_LSB-1:0] = bus.wdata;
            nxt_load_pend = 1'b1;
        end
        if (bus.wr && hit(bus.addr, CTS_OFS_CNT_HI))
        begin
            nxt_cnt_pipe[CNT_W-1:CTS_MD_LSB] = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, CTS_OFS_CNT_LO))
        begin
            nxt_cnt_pipe[CTS_MD_LSB-1:0] = bus.wdata;
        end
    end

    // read data comes from the capture latches only, never the counters,
    // so a three-byte read cannot tear while the channel runs
    always_comb
    begin
        nxt_rd_data = rd_data_ff;
        if (bus.rd)
        begin
            nxt_rd_data = CTS_RD_ZERO;
            if (hit(bus.addr, CTS_OFS_PTR_HI))
            begin
                nxt_rd_data[CTS_HI_W-1:0] =
                    addr_capt_ff[ADDR_W-1:CTS_HI_LSB];
            end
            else if (hit(bus.addr, CTS_OFS_PTR_MD))
            begin
                nxt_rd_data = addr_capt_ff[CTS_HI_LSB-1:CTS_MD_LSB];
            end
            else if (hit(bus.addr, CTS_OFS_PTR_LO))
            begin
                nxt_rd_data = addr_capt_ff[CTS_MD_LSB-1:0];
            end
            else if (hit(bus.addr, CTS_OFS_CNT_HI))
            begin
                nxt_rd_data = cnt_capt_ff[CNT_W-1:CTS_MD_LSB];
            end
            else if (hit(bus.addr, CTS_OFS_CNT_LO))
            begin
                nxt_rd_data = cnt_capt_ff[CTS_MD_LSB-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_ff <= ST_IDLE;
            addr_pipe_ff <= '0;
            addr_cnt_ff <= '0;
            addr_capt_ff <= '0;
            cnt_pipe_ff <= '0;
            cnt_ff <= '0;
            cnt_capt_ff <= '0;
            load_pend_ff <= 1'b0;
            reject_ff <= 1'b0;
            rd_data_ff <= CTS_RD_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_pipe_ff <= nxt_addr_pipe;
            addr_cnt_ff <= nxt_addr_cnt;
            addr_capt_ff <= nxt_addr_capt;
            cnt_pipe_ff <= nxt_cnt_pipe;
            cnt_ff <= nxt_cnt;
            cnt_capt_ff <= nxt_cnt_capt;
            load_pend_ff <= nxt_load_pend;
            reject_ff <= nxt_reject;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // status and data outputs
    assign stat.busy = active;
    assign stat.very_busy = (state_ff == ST_VBUSY)
        || (state_ff == ST_VBUSY_REJ);
    assign stat.cmd_reject = reject_ff;
    assign stat.sync_busy = sync_busy;
    assign xfer_active = active;
    assign pio_enable = !slave_mode;
    assign buf_addr = addr_cnt_ff;
    assign bytes_left = cnt_ff;
    assign rd_data = rd_data_ff;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    go_delay_a: assert property (cmd_raw.go && !sync_busy
        |-> ##10 cmd.go)
        else $error("start did not act ten clocks after write");
    halt_idle_a: assert property (cmd.halt
        |=> state_ff == ST_IDLE && !reject_ff)
        else $error("stop did not return channel to idle");
    preset_addr_a: assert property (state_ff == ST_IDLE && cmd.go
        && !err_uncleared && !cmd.halt && load_pend_ff
        |=> addr_cnt_ff == $past(addr_pipe_ff) && active)
        else $error("address not preset on start");
    keep_addr_a: assert property (state_ff == ST_IDLE && cmd.go
        && !err_uncleared && !cmd.halt && !load_pend_ff
        |=> addr_cnt_ff == $past(addr_cnt_ff))
        else $error("address moved on start without pending");
    ptr_pend_a: assert property (bus.wr && hit(bus.addr, CTS_OFS_PTR_LO)
        |=> load_pend_ff)
        else $error("pointer write did not set pending");
    cnt_load_a: assert property (state_ff == ST_VBUSY && done
        && !cmd.go && !cmd.halt && !xfer_err
        |=> cnt_ff == $past(cnt_pipe_ff) && state_ff == ST_BUSY)
        else $error("continuation did not reload counter");
    reject_err_a: assert property (state_ff == ST_IDLE && cmd.go
        && err_uncleared && !cmd.halt
        |=> state_ff == ST_REJECT ##1 state_ff == ST_REJECT
            || cmd.halt)
        else $error("start with error not rejected");
    err_capt_a: assert property (active && xfer_err && !cmd.halt
        && !cmd.capt
        |=> cnt_capt_ff == $past(cnt_ff)
            && addr_capt_ff == $past(addr_cnt_ff))
        else $error("error did not capture counters");
    down_cnt_a: assert property (count_byte && !cmd.halt && !xfer_err
        && !cmd.go |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
        else $error("byte did not decrement counter");
    redund_skip_a: assert property (ecc_idle_en && byte_is_redund
        && active && !cmd.go && !cmd.halt && !xfer_err && !done
        |=> cnt_ff == $past(cnt_ff))
        else $error("redundancy byte was counted");

    go_busy_c: cover property (state_ff == ST_IDLE ##1 state_ff == ST_BUSY);
    chain_c: cover property (state_ff == ST_VBUSY ##1 state_ff == ST_BUSY);
    reject_c: cover property (state_ff == ST_VBUSY_REJ
        ##1 state_ff == ST_REJECT);

endmodule : cts_channel

// >>> verif/cts_fw_model.sv
// firmware model driving the channel register bus
`timescale 1ns/1ps
module cts_fw_model
    import cts_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // channel side
    input wire cts_pkg::cts_stat_s stat,
    input wire logic [7:0] rd_data,
    output cts_pkg::cts_bus_s bus
);
    initial bus = '0;

    // one strobe cycle; channel registers are left alone while synchronising
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        while (stat.sync_busy !== 1'b0 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        #1;
        bus = {w, !w, a, d};
        @(posedge ref_clk);
        #1;
        bus = '0;
    endtask : acc

    // queued parameters are only touched outside very busy
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        if (stat.very_busy !== 1'b1)
            acc(1'b1, a, d);
    endtask : pwr

    // read data is registered, so take it one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        @(posedge ref_clk);
        #1;
        d = rd_data;
    endtask : rd
endmodule : cts_fw_model

// >>> verif/channel_transfer_sequencer_tb.sv
// self-checking bench for the channel transfer sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("BAD %s exp %0h got %0h", nm, e, g); \
        end \
    end
module channel_transfer_sequencer_tb;
    import cts_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    cts_bus_s bus;
    logic [7:0] rd_data, d;
    logic byte_done, byte_is_redund, xfer_err, err_uncleared;
    logic ecc_idle_en, slave_mode, xfer_active, pio_enable;
    cts_stat_s stat;
    logic [19:0] buf_addr;
    logic [15:0] bytes_left;
    logic [31:0] lf = 32'h0000_77aa;
    int n_fail, n_checks, cyc, st, e_addr, e_cnt, p_addr, p_cnt;
    int c_addr, c_cnt;
    bit pend, rej_pend;

    always #50 ref_clk = ~ref_clk;

    cts_channel dut_u (.ref_clk(ref_clk), .srst(srst), .bus(bus),
        .rd_data(rd_data), .byte_done(byte_done),
        .byte_is_redund(byte_is_redund), .xfer_err(xfer_err),
        .err_uncleared(err_uncleared), .ecc_idle_en(ecc_idle_en),
        .slave_mode(slave_mode), .stat(stat), .xfer_active(xfer_active),
        .pio_enable(pio_enable), .buf_addr(buf_addr),
        .bytes_left(bytes_left));

    cts_fw_model fw_u (.ref_clk(ref_clk), .stat(stat), .rd_data(rd_data),
        .bus(bus));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // a hung handshake must still reach the verdict
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk_state();
        `CHK("busy", st == 1 || st == 2, stat.busy)
        `CHK("active", st == 1 || st == 2, xfer_active)
        `CHK("very_busy", st == 2, stat.very_busy)
        `CHK("reject", st == 3 || rej_pend, stat.cmd_reject)
        `CHK("buf_addr", e_addr, buf_addr)
        `CHK("bytes_left", e_cnt, bytes_left)
        `CHK("pio", !slave_mode, pio_enable)
    endtask : chk_state

    // reads only ever see the capture latches
    task automatic chk_regs();
        fw_u.rd(CTS_OFS_PTR_HI, d);
        `CHK("ptr_hi", (c_addr >> 16) & 15, d)
        fw_u.rd(CTS_OFS_PTR_MD, d);
        `CHK("ptr_md", (c_addr >> 8) & 255, d)
        fw_u.rd(CTS_OFS_PTR_LO, d);
        `CHK("ptr_lo", c_addr & 255, d)
        fw_u.rd(CTS_OFS_CNT_HI, d);
        `CHK("cnt_hi", (c_cnt >> 8) & 255, d)
        fw_u.rd(CTS_OFS_CNT_LO, d);
        `CHK("cnt_lo", c_cnt & 255, d)
        fw_u.rd(8'h40, d);
        `CHK("unmapped", 0, d)
    endtask : chk_regs

    task automatic set_addr(input logic [19:0] a);
        fw_u.pwr(CTS_OFS_PTR_HI, {4'h0, a[19:16]});
        fw_u.pwr(CTS_OFS_PTR_MD, a[15:8]);
        fw_u.pwr(CTS_OFS_PTR_LO, a[7:0]);
        p_addr = a;
        pend = 1;
    endtask : set_addr

    task automatic set_cnt(input logic [15:0] c);
        fw_u.pwr(CTS_OFS_CNT_HI, c[15:8]);
        fw_u.pwr(CTS_OFS_CNT_LO, c[7:0]);
        p_cnt = c;
    endtask : set_cnt

    task automatic load();
        e_cnt = p_cnt;
        if (pend)
            e_addr = p_addr;
        pend = 0;
    endtask : load

    // state must not move before the tenth edge after the write
    task automatic cmd(input logic [7:0] a);
        fw_u.acc(1'b1, a, 8'h00);
        `CHK("sync_busy", 1'b1, stat.sync_busy)
        repeat (9) @(posedge ref_clk);
        #1;
        chk_state();
        @(posedge ref_clk);
        #1;
        if (a == CTS_OFS_CAPT)
        begin
            c_addr = e_addr;
            c_cnt = e_cnt;
        end
        else if (a == CTS_OFS_HALT)
        begin
            st = 0;
            rej_pend = 0;
        end
        else if (st == 0 && err_uncleared)
            st = 3;
        else if (st == 0)
        begin
            load();
            st = 1;
        end
        else if (st == 1)
            st = 2;
        else if (st == 2)
            rej_pend = 1;
        chk_state();
    endtask : cmd

    // back-to-back byte strobes, one per clock
    task automatic run(input int n, input bit red);
        @(posedge ref_clk);
        #1;
        byte_is_redund = red;
        byte_done = 1'b1;
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            if ((st == 1 || st == 2) && e_cnt != 0 && !(ecc_idle_en && red))
            begin
                e_addr = (e_addr + 1) & 32'h000f_ffff;
                e_cnt--;
            end
        end
        byte_done = 1'b0;
        chk_state();
    endtask : run

    // edge after the counter reaches zero
    task automatic fin();
        @(posedge ref_clk);
        #1;
        if (st == 1)
        begin
            c_addr = e_addr;
            c_cnt = e_cnt;
            st = 0;
        end
        else if (rej_pend)
        begin
            st = 3;
            rej_pend = 0;
        end
        else
        begin
            load();
            st = 1;
        end
        chk_state();
    endtask : fin

    initial
    begin
        {byte_done, byte_is_redund, xfer_err, err_uncleared} = '0;
        {ecc_idle_en, slave_mode} = '0;
        repeat (16) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk_state();
        chk_regs();
        slave_mode = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_state();
        slave_mode = 1'b0;
        // first transfer, queued second one continues the address
        lf = lfsr(lf);
        set_addr(lf[19:0]);
        lf = lfsr(lf);
        set_cnt(16'h0003 + lf[2:0]);
        cmd(CTS_OFS_GO);
        set_cnt(16'h0002);
        cmd(CTS_OFS_GO);
        run(e_cnt, 1'b0);
        fin();
        run(2, 1'b0);
        fin();
        chk_regs();
        // snapshot mid-transfer, then an error
        lf = lfsr(lf);
        set_cnt(16'h0006 + lf[3:0]);
        cmd(CTS_OFS_GO);
        run(2, 1'b0);
        cmd(CTS_OFS_CAPT);
        chk_regs();
        run(1, 1'b0);
        xfer_err = 1'b1;
        @(posedge ref_clk);
        #1;
        xfer_err = 1'b0;
        c_addr = e_addr;
        c_cnt = e_cnt;
        st = 0;
        chk_state();
        chk_regs();
        // redundancy bytes skipped only with idle enable
        for (int i = 0; i < 2; i++)
        begin
            ecc_idle_en = i[0];
            lf = lfsr(lf);
            set_addr(lf[19:0]);
            set_cnt(16'h0002);
            cmd(CTS_OFS_GO);
            run(2, 1'b1);
            if (e_cnt != 0)
                run(2, 1'b0);
            fin();
        end
        ecc_idle_en = 1'b0;
        // third start while very busy is rejected at completion
        cmd(CTS_OFS_GO);
        cmd(CTS_OFS_GO);
        cmd(CTS_OFS_GO);
        run(2, 1'b0);
        fin();
        cmd(CTS_OFS_HALT);
        // start with an error still pending
        err_uncleared = 1'b1;
        cmd(CTS_OFS_GO);
        err_uncleared = 1'b0;
        cmd(CTS_OFS_HALT);
        // stop from very busy
        set_cnt(16'h0005);
        cmd(CTS_OFS_GO);
        cmd(CTS_OFS_GO);
        cmd(CTS_OFS_HALT);
        end_sim();
    end
endmodule : channel_transfer_sequencer_tb
